// ===== pkg/socp_defines.svh
// Constants of the six-output capture/compare PWM unit.
// Included by the package and by the design modules; definitions only.
`ifndef SOCP_DEFINES_SVH
`define SOCP_DEFINES_SVH

`define SOCP_MAIN_W      16
`define SOCP_AUX_W       10
`define SOCP_CH_N        3
`define SOCP_PRE_SEL_W   4
`define SOCP_PRE_CNT_W   16
`define SOCP_DEAD_W      8
`define SOCP_HALL_W      3
`define SOCP_PAT_W       6
`define SOCP_MAIN_RST    16'h0000
`define SOCP_AUX_RST     10'h000
`define SOCP_PRE_RST     16'h0000
`define SOCP_STEP_FIRST  3'h1
`define SOCP_STEP_LAST   3'h6

`endif

// ===== pkg/socp_pkg.sv
// Types shared by the unit's modules.
// Assumes socp_defines.svh is on the include path.
`include "socp_defines.svh"

package socp_pkg;

    typedef logic [`SOCP_MAIN_W-1:0] socp_main_t;
    typedef logic [`SOCP_AUX_W-1:0]  socp_aux_t;

    // Static configuration, driven by the surrounding system.
    typedef struct packed {
        logic [`SOCP_PRE_SEL_W-1:0] main_pre_sel;
        logic [`SOCP_PRE_SEL_W-1:0] aux_pre_sel;
        logic [`SOCP_DEAD_W-1:0]    dead_ticks;
        logic [`SOCP_CH_N-1:0]      capture_mode;
        logic [`SOCP_CH_N-1:0]      modulate_en;
        logic                       block_comm_en;
        logic                       comm_from_hall;
    } socp_cfg_t;

    typedef struct packed {
        socp_main_t [`SOCP_CH_N-1:0] compare;
        socp_aux_t                   aux_compare;
    } socp_cmp_t;

    // Bit 2*i is the high-side output of channel i, bit 2*i+1 the low side.
    typedef logic [`SOCP_PAT_W-1:0] socp_pattern_t;
    typedef socp_pattern_t [7:0]    socp_pat_table_t;

    typedef struct packed {
        socp_main_t [`SOCP_CH_N-1:0] value;
        logic [`SOCP_CH_N-1:0]       event_flag;
    } socp_capture_t;

endpackage

// ===== design/socp_deadtime.sv
// One complementary output pair with dead-time insertion.
// Assumes pwm_i and tick_i come from logic on the same clock.
`timescale 1ns/1ps
`include "socp_defines.svh"

module socp_deadtime
    import socp_pkg::*;
#(
    parameter int DEAD_W = `SOCP_DEAD_W
) (
    input  wire logic              clk_i,
    input  wire logic              rst_n_i,
    input  wire logic              pwm_i,
    input  wire logic              tick_i,
    input  wire logic [DEAD_W-1:0] dead_i,
    output logic                   hi_o,
    output logic                   lo_o
);

    logic              level;
    logic [DEAD_W-1:0] gap;
    logic              next_level;
    logic [DEAD_W-1:0] next_gap;
    logic              next_hi;
    logic              next_lo;

    // On every change of the demand both sides go off; the new side turns on only
    // after the gap has run out, so the pair can never conduct at once.
    always_comb begin
        next_level = pwm_i;
        next_gap   = gap;
        next_hi    = hi_o;
        next_lo    = lo_o;
        if (pwm_i != level) begin
            next_gap = dead_i;
            next_hi  = 1'b0;
            next_lo  = 1'b0;
        end else if (gap != '0) begin
            if (tick_i) begin
                next_gap = gap - 1'b1;
            end
        end else begin
            next_hi = level;
            next_lo = ~level;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            level <= 1'b0;
            gap   <= '0;
            hi_o  <= 1'b0;
            lo_o  <= 1'b0;
        end else begin
            level <= next_level;
            gap   <= next_gap;
            hi_o  <= next_hi;
            lo_o  <= next_lo;
        end
    end

endmodule

// ===== design/socp_top.sv
// Capture/compare and PWM unit: three 16-bit channels on the main timer, one 10-bit
// compare channel on the auxiliary timer, dead time and block commutation.
// Assumes capture and hall pins arrive asynchronously; configuration is quasi-static.
`timescale 1ns/1ps
`include "socp_defines.svh"

module socp_top
    import socp_pkg::*;
#(
    parameter int CH_N = `SOCP_CH_N
) (
    input  wire logic                    REF_CLK_I,
    input  wire logic                    RST_N_I,
    input  wire socp_cfg_t               CFG_I,
    input  wire socp_cmp_t               CMP_I,
    input  wire socp_pat_table_t         PAT_TABLE_I,
    input  wire logic [CH_N-1:0]         CC_PIN_I,
    input  wire logic [`SOCP_HALL_W-1:0] HALL_I,
    output logic [CH_N-1:0]              CC_PIN_O,
    output logic [CH_N-1:0]              CC_PIN_OE_O,
    output logic [CH_N-1:0]              CC_LOW_O,
    output logic                         AUX_PWM_O,
    output socp_capture_t                CAPTURE_O,
    output socp_main_t                   MAIN_COUNT_O,
    output socp_aux_t                    AUX_COUNT_O
);

    localparam int SYNC_W = CH_N + `SOCP_HALL_W;

    logic [`SOCP_PRE_CNT_W-1:0] main_pre;
    logic [`SOCP_PRE_CNT_W-1:0] aux_pre;
    logic [`SOCP_PRE_CNT_W-1:0] next_main_pre;
    logic [`SOCP_PRE_CNT_W-1:0] next_aux_pre;
    logic [`SOCP_PRE_CNT_W-1:0] main_mask;
    logic [`SOCP_PRE_CNT_W-1:0] aux_mask;
    logic                       main_tick;
    logic                       aux_tick;
    socp_main_t                 main_count;
    socp_aux_t                  aux_count;
    socp_main_t                 next_main_count;
    socp_aux_t                  next_aux_count;
    logic                       main_wrap;

    logic [SYNC_W-1:0]          sync_meta;
    logic [SYNC_W-1:0]          sync_pin;
    logic [SYNC_W-1:0]          sync_prev;
    logic [CH_N-1:0]            pin_edge;
    logic [`SOCP_HALL_W-1:0]    hall_code;
    logic [1:0]                 warm;
    logic [1:0]                 next_warm;

    socp_capture_t              next_capture;
    logic [2:0]                 step;
    logic [2:0]                 next_step;
    socp_pattern_t              pattern;

    logic [CH_N-1:0]            cmp_level;
    logic [CH_N-1:0]            pwm_demand;
    logic [CH_N-1:0]            pair_hi;
    logic [CH_N-1:0]            pair_lo;
    logic                       aux_level;
    logic [CH_N-1:0]            next_out_hi;
    logic [CH_N-1:0]            next_out_lo;
    logic [CH_N-1:0]            next_oe;

    // Prescalers divide by a power of two, 2**sel; sel of zero ticks every cycle.
    always_comb begin
        main_mask     = (`SOCP_PRE_CNT_W'(1) << CFG_I.main_pre_sel) - 1'b1;
        aux_mask      = (`SOCP_PRE_CNT_W'(1) << CFG_I.aux_pre_sel) - 1'b1;
        main_tick     = (main_pre & main_mask) == main_mask;
        aux_tick      = (aux_pre & aux_mask) == aux_mask;
        next_main_pre = main_pre + 1'b1;
        next_aux_pre  = aux_pre + 1'b1;
        // Free running: the counters simply roll over at their full width.
        next_main_count = main_tick ? main_count + 1'b1 : main_count;
        next_aux_count  = aux_tick ? aux_count + 1'b1 : aux_count;
        main_wrap       = main_tick && (main_count == '1);
    end

    always_ff @(posedge REF_CLK_I) begin
        if (!RST_N_I) begin
            main_pre   <= `SOCP_PRE_RST;
            aux_pre    <= `SOCP_PRE_RST;
            main_count <= `SOCP_MAIN_RST;
            aux_count  <= `SOCP_AUX_RST;
        end else begin
            main_pre   <= next_main_pre;
            aux_pre    <= next_aux_pre;
            main_count <= next_main_count;
            aux_count  <= next_aux_count;
        end
    end

    // Pins are asynchronous; only the second stage and its delayed copy are looked at.
    always_ff @(posedge REF_CLK_I) begin
        if (!RST_N_I) begin
            sync_meta <= '0;
            sync_pin  <= '0;
            sync_prev <= '0;
            warm      <= 2'h0;
        end else begin
            sync_meta <= {HALL_I, CC_PIN_I};
            sync_pin  <= sync_meta;
            sync_prev <= sync_pin;
            warm      <= next_warm;
        end
    end

    // Capture on either edge of a pin in capture mode; the event flag lasts one cycle.
    always_comb begin
        // A pin idling high would fake an edge after reset; edges count once both stages and the delayed copy hold samples.
        next_warm    = (warm == 2'h3) ? warm : warm + 2'h1;
        pin_edge     = (sync_pin[CH_N-1:0] ^ sync_prev[CH_N-1:0]) & CFG_I.capture_mode & {CH_N{warm == 2'h3}};
        hall_code    = sync_pin[SYNC_W-1:CH_N];
        next_capture = CAPTURE_O;
        for (int i = 0; i < CH_N; i++) begin
            next_capture.event_flag[i] = pin_edge[i];
            if (pin_edge[i]) begin
                next_capture.value[i] = main_count;
            end
        end
    end

    // Timer-driven commutation walks steps 1..6, one step per main timer rollover.
    always_comb begin
        next_step = step;
        if (main_wrap) begin
            next_step = (step == `SOCP_STEP_LAST) ? `SOCP_STEP_FIRST : step + 1'b1;
        end
        pattern = CFG_I.comm_from_hall ? PAT_TABLE_I[hall_code] : PAT_TABLE_I[step];
    end

    always_ff @(posedge REF_CLK_I) begin
        if (!RST_N_I) begin
            CAPTURE_O <= '0;
            step      <= `SOCP_STEP_FIRST;
        end else begin
            CAPTURE_O <= next_capture;
            step      <= next_step;
        end
    end

    // Edge-aligned PWM: output active while the counter is below the compare value.
    always_comb begin
        aux_level = aux_count < CMP_I.aux_compare;
        for (int i = 0; i < CH_N; i++) begin
            cmp_level[i]  = main_count < CMP_I.compare[i];
            pwm_demand[i] = cmp_level[i] & (aux_level | ~CFG_I.modulate_en[i]);
        end
    end

    // The gap counts main prescaler ticks for every pair alike.
    for (genvar g = 0; g < CH_N; g++) begin : g_pair
        socp_deadtime #(
            .DEAD_W (`SOCP_DEAD_W)
        ) u_dead (
            .clk_i   (REF_CLK_I),
            .rst_n_i (RST_N_I),
            .pwm_i   (pwm_demand[g]),
            .tick_i  (main_tick),
            .dead_i  (CFG_I.dead_ticks),
            .hi_o    (pair_hi[g]),
            .lo_o    (pair_lo[g])
        );
    end

    // Block commutation only ever masks outputs off, so it cannot break the dead gap.
    always_comb begin
        for (int i = 0; i < CH_N; i++) begin
            next_out_hi[i] = pair_hi[i];
            next_out_lo[i] = pair_lo[i];
            if (CFG_I.block_comm_en) begin
                next_out_hi[i] = pair_hi[i] & pattern[2*i];
                next_out_lo[i] = pair_lo[i] & pattern[2*i+1];
            end
            next_oe[i] = ~CFG_I.capture_mode[i];
        end
    end

    always_ff @(posedge REF_CLK_I) begin
        if (!RST_N_I) begin
            CC_PIN_O     <= '0;
            CC_LOW_O     <= '0;
            CC_PIN_OE_O  <= '0;
            AUX_PWM_O    <= 1'b0;
            MAIN_COUNT_O <= `SOCP_MAIN_RST;
            AUX_COUNT_O  <= `SOCP_AUX_RST;
        end else begin
            CC_PIN_O     <= next_out_hi;
            CC_LOW_O     <= next_out_lo & next_oe;
            CC_PIN_OE_O  <= next_oe;
            AUX_PWM_O    <= aux_level;
            MAIN_COUNT_O <= main_count;
            AUX_COUNT_O  <= aux_count;
        end
    end

endmodule

// ===== tb/socp_motor.sv
// Hall sensors and power stage facing the unit's outputs.
// Assumes the bench pulses adv_i once per commutation step.
`timescale 1ns/1ps
module socp_motor (
    input  wire logic       clk_i,
    input  wire logic       adv_i,
    input  wire logic [2:0] hi_i,
    input  wire logic [2:0] lo_i,
    output logic [2:0]      hall_o,
    output logic            shoot_o
);
    logic [2:0] pos = 3'h0;
    logic [2:0] code [6] = '{3'h1, 3'h3, 3'h2, 3'h6, 3'h4, 3'h5};
    initial shoot_o = 1'b0;
    assign hall_o = code[pos];
    // A shorted bridge leg is latched so it cannot hide between samples.
    always @(posedge clk_i) begin
        pos <= adv_i ? ((pos == 3'h5) ? 3'h0 : pos + 3'h1) : pos;
        shoot_o <= shoot_o | (|(hi_i & lo_i));
    end
endmodule

// ===== tb/socp_sva.sv
// Port checker for the capture/compare PWM unit.
// Assumes it is bound onto socp_top; everything runs on REF_CLK_I.
`timescale 1ns/1ps
module socp_sva
    import socp_pkg::*;
#(
    parameter int CH_N = 3
) (
    input wire logic            REF_CLK_I,
    input wire logic            RST_N_I,
    input wire socp_cfg_t       CFG_I,
    input wire socp_cmp_t       CMP_I,
    input wire socp_pat_table_t PAT_TABLE_I,
    input wire logic [2:0]      HALL_I,
    input wire logic [CH_N-1:0] CC_PIN_O,
    input wire logic [CH_N-1:0] CC_PIN_OE_O,
    input wire logic [CH_N-1:0] CC_LOW_O,
    input wire logic            AUX_PWM_O,
    input wire socp_capture_t   CAPTURE_O,
    input wire socp_main_t      MAIN_COUNT_O,
    input wire socp_aux_t       AUX_COUNT_O
);
    logic [1:0] age, next_age;
    logic [7:0] off, next_off;
    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (!RST_N_I);
    // The off counter starts full so a gap shortened by reset never fires.
    always_comb begin
        next_age = (age == 2'h3) ? age : age + 2'h1;
        next_off = (CC_PIN_O[0] | CC_LOW_O[0]) ? 8'h00 : off + {7'h00, off != 8'hff};
        if (!RST_N_I) begin
            next_age = 2'h0;
            next_off = 8'hff;
        end
    end
    always_ff @(posedge REF_CLK_I) begin
        age <= next_age;
        off <= next_off;
    end
    property p_overlap; (CC_PIN_O & CC_LOW_O) == '0; endproperty
    a_overlap: assert property (p_overlap) else $error("pair overlap");
    property p_gap; ($rose(CC_PIN_O[0]) && age == 2'h3 && !CFG_I.block_comm_en && CFG_I.main_pre_sel == 4'h0)
        |-> off >= CFG_I.dead_ticks; endproperty
    a_gap: assert property (p_gap) else $error("dead gap short");
    property p_step; (age == 2'h3 && CFG_I.main_pre_sel == 4'h0 && $past(CFG_I.main_pre_sel) == 4'h0
        && $past(CFG_I.main_pre_sel, 2) == 4'h0)
        |-> MAIN_COUNT_O == $past(MAIN_COUNT_O) + 16'h0001; endproperty
    a_step: assert property (p_step) else $error("main timer step");
    property p_aux; (age == 2'h3 && $stable(CMP_I.aux_compare)) |-> AUX_PWM_O == (AUX_COUNT_O < CMP_I.aux_compare);
        endproperty
    a_aux: assert property (p_aux) else $error("aux pwm level");
    property p_cap; CAPTURE_O.event_flag[2] |-> CAPTURE_O.value[2] == MAIN_COUNT_O; endproperty
    a_cap: assert property (p_cap) else $error("capture value");
    property p_quiet; (CFG_I.capture_mode[2] && $past(CFG_I.capture_mode[2]) && $past(CFG_I.capture_mode[2], 2))
        |-> !CC_PIN_OE_O[2] && !CC_LOW_O[2]; endproperty
    a_quiet: assert property (p_quiet) else $error("capture pin driven");
    property p_oe; (age == 2'h3 && !CFG_I.capture_mode[0] && !$past(CFG_I.capture_mode[0])) |-> CC_PIN_OE_O[0];
        endproperty
    a_oe: assert property (p_oe) else $error("compare pin not driven");
    property p_hall; (CFG_I.block_comm_en && CFG_I.comm_from_hall && $stable(HALL_I) && $stable(CFG_I))[*5]
        |-> (CC_PIN_O & ~{PAT_TABLE_I[HALL_I][4], PAT_TABLE_I[HALL_I][2], PAT_TABLE_I[HALL_I][0]}) == '0; endproperty
    a_hall: assert property (p_hall) else $error("hall pattern mask");
endmodule
bind socp_top socp_sva #(.CH_N(CH_N)) socp_sva_inst (.REF_CLK_I(REF_CLK_I), .RST_N_I(RST_N_I), .CFG_I(CFG_I),
    .CMP_I(CMP_I), .PAT_TABLE_I(PAT_TABLE_I), .HALL_I(HALL_I), .CC_PIN_O(CC_PIN_O), .CC_PIN_OE_O(CC_PIN_OE_O),
    .CC_LOW_O(CC_LOW_O), .AUX_PWM_O(AUX_PWM_O), .CAPTURE_O(CAPTURE_O), .MAIN_COUNT_O(MAIN_COUNT_O),
    .AUX_COUNT_O(AUX_COUNT_O));

// ===== tb/six_output_capture_compare_pwm_tb.sv
// Self-checking bench for the capture/compare PWM unit.
// Assumes socp_top, the motor model and the checker are compiled first.
`timescale 1ns/1ps
module six_output_capture_compare_pwm_tb import socp_pkg::*;;
    logic            clk = 1'b0;
    logic            rst_n = 1'b0;
    socp_cfg_t       cfg = '0;
    socp_cmp_t       cmp = '0;
    socp_pat_table_t pat = '0;
    logic [2:0]      pin = 3'h0;
    logic            adv = 1'b0;
    logic [2:0]      hall, hi, lo, oe;
    logic            pwm, shoot;
    socp_capture_t   cap;
    socp_main_t      mcnt;
    socp_aux_t       acnt;
    int              fail_count = 0;
    int              checks = 0;
    always #2 clk = ~clk;
    socp_top socp_top_inst (.REF_CLK_I(clk), .RST_N_I(rst_n), .CFG_I(cfg), .CMP_I(cmp), .PAT_TABLE_I(pat),
        .CC_PIN_I(pin), .HALL_I(hall), .CC_PIN_O(hi), .CC_PIN_OE_O(oe), .CC_LOW_O(lo), .AUX_PWM_O(pwm),
        .CAPTURE_O(cap), .MAIN_COUNT_O(mcnt), .AUX_COUNT_O(acnt));
    socp_motor socp_motor_inst (.clk_i(clk), .adv_i(adv), .hi_i(hi), .lo_i(lo), .hall_o(hall), .shoot_o(shoot));
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] lo_b, input logic [15:0] hi_b);
        checks++;
        if ((got >= lo_b && got <= hi_b) !== 1'b1) begin
            fail_count++;
            $display("wrong value at %0t: got %h, want %h..%h", $time, got, lo_b, hi_b);
        end
    endtask
    task automatic wrap_up;
        $display("fail_count=%0d checks=%0d", fail_count, checks);
        if (fail_count == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic hang;
        fail_count++;
        wrap_up();
    endtask
    task automatic t_count;
        socp_main_t m;
        socp_aux_t  a;
        chk(mcnt, 16'h0, 16'h0);
        rst_n = 1'b1;
        tick(10);
        chk(mcnt, 16'h9, 16'h9);
        cfg.main_pre_sel = 4'h2;
        cfg.aux_pre_sel = 4'h1;
        tick(2);
        m = mcnt;
        a = acnt;
        tick(64);
        m = mcnt - m;
        a = acnt - a;
        chk(m, 16'h10, 16'h10);
        chk(16'(a), 16'h20, 16'h20);
        cfg.main_pre_sel = 4'h0;
        cfg.aux_pre_sel = 4'h0;
    endtask
    // Any 1024-cycle window spans exactly one auxiliary period.
    task automatic t_aux;
        int n;
        n = 0;
        cmp.aux_compare = 10'h100;
        tick(2);
        repeat (1024) begin
            n += pwm;
            tick(1);
        end
        chk(16'(n), 16'h100, 16'h100);
    endtask
    task automatic t_dead(input logic [7:0] d);
        int i;
        int n;
        cfg.dead_ticks = d;
        cmp.compare = {3{16'hffff}};
        tick(30);
        cmp.compare = {3{mcnt + 16'h001e}};
        for (i = 0; i < 100 && hi[0] !== 1'b0; i++) tick(1);
        for (n = 0; n < 300 && lo[0] !== 1'b1; n++) tick(1);
        if (i == 100 || n == 300) hang();
        chk(16'(n), {8'h0, d}, {8'h0, d} + 16'h2);
        chk(16'(lo[2]), 16'h1, 16'h1);
    endtask
    task automatic t_mod;
        int n;
        n = 0;
        cfg.dead_ticks = 8'h00;
        cfg.modulate_en = 3'h2;
        cmp.compare = {3{16'hffff}};
        tick(8);
        repeat (1024) begin
            n += hi[1];
            tick(1);
        end
        chk(16'(n), 16'h00fa, 16'h0100);
        chk(16'(hi[0]), 16'h1, 16'h1);
        cfg.modulate_en = 3'h0;
    endtask
    task automatic t_cap;
        socp_main_t t0;
        int         i;
        cfg.capture_mode = 3'h4;
        tick(3);
        chk(16'({oe[2], lo[2]}), 16'h0, 16'h0);
        repeat (2) begin
            t0 = mcnt;
            pin = ~pin;
            for (i = 0; i < 8 && cap.event_flag[2] !== 1'b1; i++) tick(1);
            if (i == 8) hang();
            chk(cap.value[2], t0 + 16'h1, t0 + 16'h5);
            chk(16'(cap.event_flag[0]), 16'h0, 16'h0);
            tick(1);
            chk(16'(cap.event_flag[2]), 16'h0, 16'h0);
        end
        cfg.capture_mode = 3'h0;
    endtask
    task automatic t_hall;
        for (int k = 0; k < 8; k++) pat[k] = 6'h01 << (2 * (k % 3));
        cfg.block_comm_en = 1'b1;
        cfg.comm_from_hall = 1'b1;
        repeat (6) begin
            adv = 1'b1;
            tick(1);
            adv = 1'b0;
            tick(8);
            chk(16'({lo, hi}), 16'(3'h1 << (hall % 3)), 16'(3'h1 << (hall % 3)));
        end
        chk(16'(shoot), 16'h0, 16'h0);
        // No main timer rollover happens in this run, so the timer-driven pattern stays on the first step.
        cfg.comm_from_hall = 1'b0;
        tick(4);
        chk(16'({lo, hi}), 16'h0002, 16'h0002);
    endtask
    initial begin
        tick(4);
        t_count();
        t_aux();
        t_dead(8'h00);
        t_dead(8'h08);
        t_mod();
        t_cap();
        t_hall();
        wrap_up();
    end
endmodule
